// ---- i2ci_ctrl.sv ----
/*
 two-wire bus initiator: queues, bit engine, release reset, dma requests.
 assumes config inputs are on CLK_I; pins pass a two-flop synchroniser.
*/
`timescale 1ns/1ns
`default_nettype none
`include "i2ci_params.svh"
module i2ci_ctrl
	import i2ci_pkg::*;
#(
	parameter int DEPTH = `I2CI_FIFO_DEPTH,
	parameter int BURST = `I2CI_DMA_BURST
) (
	input  wire logic              CLK_I,
	input  wire logic              SYS_RST_I,
	input  wire logic              RST_WE_I,
	input  wire logic              RST_REL_I,
	input  wire logic              PWR_GATE_I,
	input  wire i2ci_speed_t       SPEED_I,
	input  wire i2ci_scl_t   [3:0] SCL_CNT_I,
	input  wire logic              ADDR10_I,
	input  wire logic              RESTART_EN_I,
	input  wire logic        [9:0] TAR_I,
	input  wire logic       [31:0] HOLD_I,
	input  wire logic              CMD_VALID_I,
	input  wire i2ci_cmd_t         CMD_I,
	output logic                   CMD_READY_O,
	output logic                   RX_VALID_O,
	output logic             [7:0] RX_DATA_O,
	input  wire logic              RX_READY_I,
	input  wire logic        [1:0] INT_CLR_I,
	output i2ci_stat_t             STATUS_O,
	output logic                   INT_O,
	output logic                   DMA_TX_REQ_O,
	output logic                   DMA_RX_REQ_O,
	input  wire logic              SCL_I,
	output logic                   SCL_O,
	output logic                   SCL_OE_O,
	input  wire logic              SDA_I,
	output logic                   SDA_O,
	output logic                   SDA_OE_O
);
	localparam int LW = $clog2(DEPTH+1);
	typedef struct packed {
		i2ci_fsm_t   fsm;
		logic [15:0] tmr;
		logic [1:0]  sub;
		logic [3:0]  bitn;
		logic [8:0]  sh;
		i2ci_phase_t ph;
		logic        rd;
		logic        a10;
		logic        hdr_rd;
		logic        scl_oe;
		logic        sda_oe;
		logic        intr;
		logic        dma_tx;
		logic        dma_rx;
		logic        rx_vld;
		logic [7:0]  rx_dat;
		i2ci_stat_t  stat;
	} i2ci_st_t;
	localparam i2ci_st_t ST_RST = '{fsm: S_IDLE, ph: PH_A1, default: '0};

	i2ci_st_t         st;
	i2ci_st_t         nxt_st;
	logic             scl_s;
	logic             sda_s;
	logic             txf_vld;
	i2ci_cmd_t        txf_dat;
	logic             txf_pop;
	logic [LW-1:0]    txf_lvl;
	logic             rxf_rdy;
	logic             rxf_vld;
	logic [7:0]       rxf_dat;
	logic             rxf_pop;
	logic             rx_push;
	logic [LW-1:0]    rxf_lvl;
	logic             nx;
	logic             set_nack;
	logic             set_done;
	logic [15:0]      clock_high_count;
	logic [15:0]      clock_low_count;
	logic [15:0]      hold_cur;

	function automatic logic [8:0] addr_byte(input logic a10, input logic [9:0] tar,
		input logic rdb);
		// ten-bit header carries the two top address bits
		addr_byte = a10 ? {`I2CI_HDR10, tar[9:8], rdb, 1'b1} : {tar[6:0], rdb, 1'b1};
	endfunction

	function automatic logic [15:0] hold_of(input logic rx, input logic [31:0] h);
		logic [15:0] t;
		logic [7:0]  r;
		t = h[`I2CI_HOLD_TX_MSB:`I2CI_HOLD_TX_LSB];
		r = h[`I2CI_HOLD_RX_MSB:`I2CI_HOLD_RX_LSB];
		// clamp so a bad setting cannot break the bit engine
		if (rx) hold_of = {8'h00, (r < `I2CI_HOLD_RX_MIN) ? `I2CI_HOLD_RX_MIN : r};
		else hold_of = (t < `I2CI_HOLD_TX_MIN) ? `I2CI_HOLD_TX_MIN : t;
	endfunction

	i2ci_sync #(.W(2)) u_sync (
		.clk_i (CLK_I),
		.d_i   ({SCL_I, SDA_I}),
		.q_o   ({scl_s, sda_s})
	);

	i2ci_fifo #(.W(9), .DEPTH(DEPTH)) u_txf (
		.clk_i       (CLK_I),
		.rst_i       (SYS_RST_I),
		.clr_i       (~st.stat.rel),
		.in_valid_i  (CMD_VALID_I),
		.in_data_i   (CMD_I),
		.in_ready_o  (CMD_READY_O),
		.out_valid_o (txf_vld),
		.out_data_o  (txf_dat),
		.out_ready_i (txf_pop),
		.level_o     (txf_lvl)
	);

	i2ci_fifo #(.W(8), .DEPTH(DEPTH)) u_rxf (
		.clk_i       (CLK_I),
		.rst_i       (SYS_RST_I),
		.clr_i       (~st.stat.rel),
		.in_valid_i  (rx_push),
		.in_data_i   (st.sh[7:0]),
		.in_ready_o  (rxf_rdy),
		.out_valid_o (rxf_vld),
		.out_data_o  (rxf_dat),
		.out_ready_i (rxf_pop),
		.level_o     (rxf_lvl)
	);

	// one grade encoded, so no overlap
	assign clock_high_count = SCL_CNT_I[SPEED_I].clock_high_count;
	assign clock_low_count = SCL_CNT_I[SPEED_I].clock_low_count;
	// receive hold only while reading data
	assign hold_cur = hold_of(st.ph == PH_DATA && st.rd, HOLD_I);
	assign rxf_pop = rxf_vld & (~st.rx_vld | RX_READY_I);

	always_comb begin
		nxt_st   = st;
		txf_pop  = 1'b0;
		rx_push  = 1'b0;
		nx       = 1'b0;
		set_nack = 1'b0;
		set_done = 1'b0;
		if (!PWR_GATE_I) begin
			unique case (st.fsm)
			S_IDLE: begin
				// every new sequence opens with start
				if (txf_vld) begin
					nxt_st.rd     = txf_dat.rd;
					nxt_st.a10    = ADDR10_I;
					nxt_st.hdr_rd = 1'b0;
					nxt_st.ph     = PH_A1;
					nxt_st.bitn   = 4'h0;
					nxt_st.tmr    = 16'h0000;
					nxt_st.sh     = addr_byte(ADDR10_I, TAR_I, ~ADDR10_I & txf_dat.rd);
					nxt_st.sda_oe = 1'b1;
					nxt_st.fsm    = S_START;
				end
			end
			S_START: begin
				nxt_st.tmr = 16'(st.tmr + 1'b1);
				if (st.tmr >= clock_high_count) begin
					nxt_st.scl_oe = 1'b1;
					nxt_st.tmr    = 16'h0000;
					nxt_st.fsm    = S_LOW;
				end
			end
			S_LOW: begin
				// stall with clock low while receive queue is full
				if (!(st.ph == PH_DATA && st.rd && st.bitn == 4'h0 && !rxf_rdy)) begin
					nxt_st.tmr = 16'(st.tmr + 1'b1);
					// data changes hold clocks after fall
					if (st.tmr == hold_cur) begin
						if (st.bitn == 4'h8 && st.ph == PH_DATA && st.rd)
							nxt_st.sda_oe = txf_vld & txf_dat.rd;
						else
							nxt_st.sda_oe = ~st.sh[8];
					end
					if (st.tmr >= clock_low_count) begin
						nxt_st.scl_oe = 1'b0;
						nxt_st.tmr    = 16'h0000;
						nxt_st.fsm    = S_HIGH;
					end
				end
			end
			S_HIGH: begin
				// a target stretching the clock holds the count
				if (scl_s) nxt_st.tmr = 16'(st.tmr + 1'b1);
				if (scl_s && st.tmr >= clock_high_count) begin
					nxt_st.sh   = {st.sh[7:0], sda_s};
					nxt_st.bitn = 4'(st.bitn + 1'b1);
					nxt_st.tmr  = 16'h0000;
					if (st.bitn != 4'h8) begin
						nxt_st.scl_oe = 1'b1;
						nxt_st.fsm    = S_LOW;
					end else begin
						nxt_st.bitn = 4'h0;
						if (!(st.ph == PH_DATA && st.rd) && sda_s) begin
							set_nack      = 1'b1;
							nxt_st.scl_oe = 1'b1;
							nxt_st.sub    = 2'h0;
							nxt_st.fsm    = S_STOP;
						end else begin
							unique case (st.ph)
							PH_A1: begin
								if (st.a10 && !st.hdr_rd) begin
									nxt_st.ph     = PH_A2;
									nxt_st.sh     = {TAR_I[7:0], 1'b1};
									nxt_st.scl_oe = 1'b1;
									nxt_st.fsm    = S_LOW;
								end else begin
									nx = 1'b1;
								end
							end
							PH_A2: begin
								if (st.rd) begin
									// ten-bit read turns round with header
									nxt_st.hdr_rd = 1'b1;
									nxt_st.ph     = PH_A1;
									nxt_st.sh     = addr_byte(1'b1, TAR_I, 1'b1);
									nxt_st.scl_oe = 1'b1;
									nxt_st.sub    = 2'h0;
									nxt_st.fsm    = S_RSTART;
								end else begin
									nx = 1'b1;
								end
							end
							default: begin
								rx_push = st.rd;
								nx      = 1'b1;
							end
							endcase
						end
					end
				end
			end
			S_STOP: begin
				nxt_st.tmr = 16'(st.tmr + 1'b1);
				unique case (st.sub)
				2'h0: begin
					if (st.tmr == hold_cur) nxt_st.sda_oe = 1'b1;
					if (st.tmr >= clock_low_count) begin
						nxt_st.scl_oe = 1'b0;
						nxt_st.tmr    = 16'h0000;
						nxt_st.sub    = 2'h1;
					end
				end
				2'h1: begin
					if (!scl_s) nxt_st.tmr = 16'h0000;
					else if (st.tmr >= clock_high_count) begin
						nxt_st.sda_oe = 1'b0;
						nxt_st.tmr    = 16'h0000;
						nxt_st.sub    = 2'h2;
					end
				end
				default: begin
					// bus free time before any new start
					if (st.tmr >= clock_high_count) begin
						set_done   = 1'b1;
						nxt_st.fsm = S_IDLE;
					end
				end
				endcase
			end
			S_RSTART: begin
				nxt_st.tmr = 16'(st.tmr + 1'b1);
				if (st.sub == 2'h0) begin
					if (st.tmr == hold_cur) nxt_st.sda_oe = 1'b0;
					if (st.tmr >= clock_low_count) begin
						nxt_st.scl_oe = 1'b0;
						nxt_st.tmr    = 16'h0000;
						nxt_st.sub    = 2'h1;
					end
				end else if (!scl_s) begin
					nxt_st.tmr = 16'h0000;
				end else if (st.tmr >= clock_high_count) begin
					nxt_st.sda_oe = 1'b1;
					nxt_st.tmr    = 16'h0000;
					nxt_st.fsm    = S_START;
				end
			end
			endcase
			if (nx) begin
				nxt_st.sub = 2'h0;
				nxt_st.scl_oe = 1'b1;
				if (!txf_vld) begin
					nxt_st.fsm = S_STOP;
				end else if (txf_dat.rd != st.rd) begin
					if (RESTART_EN_I) begin
						nxt_st.rd     = txf_dat.rd;
						nxt_st.hdr_rd = 1'b0;
						nxt_st.ph     = PH_A1;
						nxt_st.sh     = addr_byte(st.a10, TAR_I, ~st.a10 & txf_dat.rd);
						nxt_st.fsm    = S_RSTART;
					end else begin
						nxt_st.fsm = S_STOP;
					end
				end else begin
					txf_pop    = 1'b1;
					nxt_st.ph  = PH_DATA;
					nxt_st.sh  = txf_dat.rd ? `I2CI_RD_IDLE : {txf_dat.data, 1'b1};
					nxt_st.fsm = S_LOW;
				end
			end
		end
		if (rxf_pop) begin
			nxt_st.rx_vld = 1'b1;
			nxt_st.rx_dat = rxf_dat;
		end else if (RX_READY_I) begin
			nxt_st.rx_vld = 1'b0;
		end
		// sticky, set beats a same-cycle clear
		nxt_st.stat.nack = set_nack | (st.stat.nack & ~INT_CLR_I[0]);
		nxt_st.stat.done = set_done | (st.stat.done & ~INT_CLR_I[1]);
		nxt_st.intr = nxt_st.stat.nack | nxt_st.stat.done;
		// request when a full burst fits
		nxt_st.dma_tx = (DEPTH - int'(txf_lvl)) >= BURST;
		nxt_st.dma_rx = int'(rxf_lvl) >= BURST;
		// held in reset until software release
		if (RST_WE_I) nxt_st.stat.rel = RST_REL_I;
		if (!st.stat.rel) begin
			nxt_st          = ST_RST;
			nxt_st.stat.rel = RST_WE_I & RST_REL_I;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) st <= ST_RST;
		else st <= nxt_st;
	end

	// open drain, only ever pulled low
	assign SCL_O        = 1'b0;
	assign SDA_O        = 1'b0;
	assign SCL_OE_O     = st.scl_oe;
	assign SDA_OE_O     = st.sda_oe;
	assign RX_VALID_O   = st.rx_vld;
	assign RX_DATA_O    = st.rx_dat;
	assign STATUS_O     = st.stat;
	assign INT_O        = st.intr;
	assign DMA_TX_REQ_O = st.dma_tx;
	assign DMA_RX_REQ_O = st.dma_rx;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	a_held_reset: assert property (!st.stat.rel |=> !SCL_OE_O && !SDA_OE_O)
		else $error("pins moved while held in reset");
	a_gate_freeze: assert property (PWR_GATE_I && st.stat.rel && $past(st.stat.rel) |=>
		$stable(SCL_OE_O) && $stable(SDA_OE_O))
		else $error("pin changed during power gate");
	a_sda_only_framing: assert property (st.stat.rel && $past(st.stat.rel) && !SCL_OE_O
		&& $past(!SCL_OE_O) && $changed(SDA_OE_O) |-> st.fsm inside {S_START, S_STOP})
		else $error("data moved while clock high outside start or stop");
	a_hold_time: assert property ((st.fsm == S_LOW) && $changed(SDA_OE_O) && $past(st.fsm == S_LOW)
		|-> $past(st.tmr) == $past(hold_cur))
		else $error("data changed at wrong hold count");
	a_low_len: assert property ($past(st.fsm) == S_LOW && st.fsm == S_HIGH && !$past(PWR_GATE_I)
		|-> $past(st.tmr) >= $past(clock_low_count) && !SCL_OE_O)
		else $error("clock low phase cut short");
	a_nack_stop: assert property (st.fsm == S_HIGH && st.bitn == 4'h8 && st.ph != PH_DATA
		&& scl_s && st.tmr >= clock_high_count && sda_s && !PWR_GATE_I && st.stat.rel
		|=> st.fsm == S_STOP && st.stat.nack && INT_O)
		else $error("missing acknowledge not followed by stop");
	a_restart_cfg: assert property ($rose(st.fsm == S_RSTART) && $past(st.ph) == PH_DATA
		|-> $past(RESTART_EN_I))
		else $error("repeated start without enable");
	a_fmt_same: assert property (st.fsm != S_IDLE && $past(st.fsm) != S_IDLE
		|-> $stable(st.a10))
		else $error("address format changed inside sequence");
	a_rx_no_drop: assert property (rx_push |-> rxf_rdy)
		else $error("byte pushed into full receive queue");
	a_dma_burst: assert property (DMA_TX_REQ_O |-> DEPTH - int'($past(txf_lvl)) >= BURST)
		else $error("transmit dma request without burst room");

	c_restart: cover property ($rose(st.fsm == S_RSTART));
	c_nack: cover property ($rose(st.stat.nack));
	c_read_byte: cover property (rx_push);
	c_stop_idle: cover property (st.fsm == S_STOP ##1 st.fsm == S_IDLE);
endmodule
`default_nettype wire

// ---- i2ci_fifo.sv ----
/*
 synchronous fifo with valid/ready on both sides and registered flags.
 assumes DEPTH is a power of two; clr_i flushes in one cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module i2ci_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       clr_i,
	input  wire logic                       in_valid_i,
	input  wire logic [W-1:0]               in_data_i,
	output logic                            in_ready_o,
	output logic                            out_valid_o,
	output logic      [W-1:0]               out_data_o,
	input  wire logic                       out_ready_i,
	output logic      [$clog2(DEPTH+1)-1:0] level_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [LW-1:0] cnt;
		logic          rdy;
		logic          vld;
	} i2ci_fst_t;
	i2ci_fst_t st;
	i2ci_fst_t nxt_st;
	logic [W-1:0] mem [DEPTH];
	logic push;
	logic pop;
	always_comb begin
		push = in_valid_i & st.rdy;
		pop  = out_ready_i & st.vld;
		nxt_st = st;
		if (push) nxt_st.wp = AW'(st.wp + 1'b1);
		if (pop) nxt_st.rp = AW'(st.rp + 1'b1);
		nxt_st.cnt = LW'(st.cnt + LW'(push) - LW'(pop));
		nxt_st.rdy = nxt_st.cnt != LW'(DEPTH);
		nxt_st.vld = nxt_st.cnt != '0;
		if (clr_i) nxt_st = '{rdy: 1'b1, default: '0};
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) st <= '{rdy: 1'b1, default: '0};
		else st <= nxt_st;
		if (push) mem[st.wp] <= in_data_i;
	end
	assign in_ready_o  = st.rdy;
	assign out_valid_o = st.vld;
	assign out_data_o  = mem[st.rp];
	assign level_o     = st.cnt;
endmodule
`default_nettype wire

// ---- i2ci_params.svh ----
/*
 two-wire initiator constants: field positions, reset values, limits.
 assumes inclusion by the controller, the only design file that reads these macros.
*/
`ifndef I2CI_PARAMS_SVH
`define I2CI_PARAMS_SVH

`define I2CI_FIFO_DEPTH 64
`define I2CI_DMA_BURST 32
`define I2CI_HOLD_TX_MSB 15
`define I2CI_HOLD_TX_LSB 0
`define I2CI_HOLD_RX_MSB 23
`define I2CI_HOLD_RX_LSB 16
`define I2CI_HOLD_TX_MIN 16'h0002
`define I2CI_HOLD_RX_MIN 8'h08
`define I2CI_HDR10 5'h1e
`define I2CI_RD_IDLE 9'h1ff
`define I2CI_REL_RST 1'b0

`endif

// ---- i2ci_pkg.sv ----
/*
 two-wire initiator types: speed grades, phases, states, carriers.
 assumes nothing beyond a SystemVerilog compiler.
*/
package i2ci_pkg;
	typedef enum logic [1:0] {
		SPD_STD   = 2'h0,
		SPD_FAST  = 2'h1,
		SPD_FPLUS = 2'h2,
		SPD_HS    = 2'h3
	} i2ci_speed_t;
	typedef enum logic [1:0] {
		PH_A1   = 2'h0,
		PH_A2   = 2'h1,
		PH_DATA = 2'h2
	} i2ci_phase_t;
	typedef enum logic [5:0] {
		S_IDLE   = 6'h01,
		S_START  = 6'h02,
		S_LOW    = 6'h04,
		S_HIGH   = 6'h08,
		S_STOP   = 6'h10,
		S_RSTART = 6'h20
	} i2ci_fsm_t;
	typedef struct packed {
		logic       rd;
		logic [7:0] data;
	} i2ci_cmd_t;
	typedef struct packed {
		logic [15:0] clock_high_count;
		logic [15:0] clock_low_count;
	} i2ci_scl_t;
	typedef struct packed {
		logic nack;
		logic done;
		logic rel;
	} i2ci_stat_t;
endpackage

// ---- i2ci_sync.sv ----
/*
 two-flop synchroniser for levels from outside the clock domain.
 assumes the input changes slowly against the clock.
*/
`timescale 1ns/1ns
`default_nettype none
module i2ci_sync #(
	parameter int W = 2
) (
	input  wire logic         clk_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} i2ci_sy_t;
	i2ci_sy_t st;
	i2ci_sy_t nxt_st;
	always_comb begin
		nxt_st.s1 = d_i;
		nxt_st.s2 = st.s1;
	end
	always_ff @(posedge clk_i) begin
		st <= nxt_st;
	end
	assign q_o = st.s2;
endmodule
`default_nettype wire

// ---- i2ci_tgt_model.sv ----
/*
 behavioural two-wire target: acks its address, logs written bytes, returns a count on reads.
 assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/1ns
`default_nettype none
module i2ci_tgt_model #(
	parameter logic [6:0] ADDR    = 7'h2a,
	parameter logic [7:0] RD_BASE = 8'h81
) (
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic nack_i,
	output logic      sda_oe_o
);
	int         cnt = 0;
	int         starts = 0;
	int         stops = 0;
	int         nw = 0;
	logic       first = 1'b0;
	logic       frm = 1'b0;
	logic       rd = 1'b0;
	logic       act = 1'b0;
	logic [7:0] sh = 8'h00;
	logic [7:0] tx = 8'h00;
	logic [7:0] rdv = RD_BASE;
	logic [7:0] log [0:255];
	initial sda_oe_o = 1'b0;
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			starts++;
			frm = 1'b1;
			cnt = 0;
			first = 1'b1;
			act = 1'b0;
		end
	end
	always @(posedge sda_i) begin
		// only a stop that closes a frame counts, not the wires settling
		if (scl_i === 1'b1 && frm) begin
			stops++;
			frm = 1'b0;
			act = 1'b0;
		end
	end
	always @(posedge scl_i) begin
		sh = {sh[6:0], sda_i};
		cnt++;
		if (cnt == 8 && (first || !rd)) begin
			log[nw[7:0]] = sh;
			nw++;
		end
		// initiator nack ends our read data
		if (cnt == 9 && rd && !first && sda_i) act = 1'b0;
	end
	always @(negedge scl_i) begin
		if (cnt == 8) begin
			if (first) begin
				act = (sh[7:1] == ADDR || sh[7:3] == 5'h1e) && !nack_i;
				rd = sh[0];
			end
			sda_oe_o = act && (first || !rd);
		end else if (cnt == 9) begin
			cnt = 0;
			first = 1'b0;
			if (act && rd) begin
				tx = rdv;
				rdv = rdv + 8'h01;
			end
			sda_oe_o = act && rd && !tx[7];
		end else if (act && rd && !first) begin
			sda_oe_o = !tx[7 - cnt];
		end
	end
endmodule
`default_nettype wire

// ---- testbench.sv ----
/*
 self-checking bench for the two-wire initiator driving one target model.
 assumes pull-ups on both wires and a 4 ns controller clock.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench
	import i2ci_pkg::*;
;
	logic            CLK_I, SYS_RST_I, RST_WE_I, RST_REL_I, PWR_GATE_I, ADDR10_I, RESTART_EN_I;
	logic            CMD_VALID_I, CMD_READY_O, RX_VALID_O, RX_READY_I, INT_O, nack_req, tgt_oe;
	logic            DMA_TX_REQ_O, DMA_RX_REQ_O, SCL_O, SCL_OE_O, SDA_O, SDA_OE_O, scl_q, sda_q;
	i2ci_speed_t     SPEED_I;
	i2ci_scl_t [3:0] SCL_CNT_I;
	logic [9:0]      TAR_I;
	logic [31:0]     HOLD_I;
	i2ci_cmd_t       CMD_I;
	logic [7:0]      RX_DATA_O;
	logic [1:0]      INT_CLR_I;
	i2ci_stat_t      STATUS_O;
	int              mismatches, cmp_count, run, lo_min, hi_min, hd_min, hd_max, gate_chg;
	// pull-ups: a released wire reads high
	wire logic       scl_w = ~SCL_OE_O;
	wire logic       sda_w = ~SDA_OE_O & ~tgt_oe;

	initial begin
		CLK_I = 1'b0;
		forever #2 CLK_I = ~CLK_I;
	end

	i2ci_ctrl u_dut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .RST_WE_I(RST_WE_I),
		.RST_REL_I(RST_REL_I), .PWR_GATE_I(PWR_GATE_I), .SPEED_I(SPEED_I),
		.SCL_CNT_I(SCL_CNT_I), .ADDR10_I(ADDR10_I), .RESTART_EN_I(RESTART_EN_I), .TAR_I(TAR_I),
		.HOLD_I(HOLD_I), .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I), .CMD_READY_O(CMD_READY_O),
		.RX_VALID_O(RX_VALID_O), .RX_DATA_O(RX_DATA_O), .RX_READY_I(RX_READY_I),
		.INT_CLR_I(INT_CLR_I), .STATUS_O(STATUS_O), .INT_O(INT_O), .DMA_TX_REQ_O(DMA_TX_REQ_O),
		.DMA_RX_REQ_O(DMA_RX_REQ_O), .SCL_I(scl_w), .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O),
		.SDA_I(sda_w), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O));
	i2ci_tgt_model u_tgt (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack_req), .sda_oe_o(tgt_oe));

	// phase lengths and hold, counted in controller clocks
	always @(posedge CLK_I) begin
		run <= (SCL_OE_O == scl_q) ? run + 1 : 1;
		if (SCL_OE_O != scl_q && scl_q && run < lo_min) lo_min <= run;
		if (SCL_OE_O != scl_q && !scl_q && run < hi_min) hi_min <= run;
		if (SCL_OE_O && scl_q && SDA_OE_O != sda_q && run < hd_min) hd_min <= run;
		if (SCL_OE_O && scl_q && SDA_OE_O != sda_q && run > hd_max) hd_max <= run;
		if (PWR_GATE_I && (SCL_OE_O != scl_q || SDA_OE_O != sda_q)) gate_chg <= gate_chg + 1;
		scl_q <= SCL_OE_O;
		sda_q <= SDA_OE_O;
	end

	task automatic step(input int n);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	// valid stays up between pushes; caller drops it
	task automatic push(input logic rd, input logic [7:0] d);
		CMD_I = '{rd: rd, data: d};
		CMD_VALID_I = 1'b1;
		while (CMD_READY_O !== 1'b1) step(1);
		step(1);
	endtask
	task automatic set_rel(input logic v);
		RST_REL_I = v;
		RST_WE_I = 1'b1;
		step(1);
		RST_WE_I = 1'b0;
		chk(STATUS_O.rel === v, "release state");
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		CMD_VALID_I = 1'b0;
		while (STATUS_O.done !== 1'b1 && n < 20000) begin
			step(1);
			n++;
		end
		step(3);
		chk(INT_O === 1'b1 && STATUS_O.done === 1'b1, "done level");
		chk(SCL_O === 1'b0 && SDA_O === 1'b0 && !SCL_OE_O && !SDA_OE_O, "lines");
		INT_CLR_I = 2'b11;
		step(1);
		INT_CLR_I = 2'b00;
		step(2);
		chk(INT_O === 1'b0 && STATUS_O === 3'b001, "flag clear");
	endtask

	task automatic t_reset();
		chk(STATUS_O === 3'b000 && INT_O === 1'b0 && CMD_READY_O === 1'b1, "reset");
		chk(!SCL_OE_O && !SDA_OE_O && !DMA_TX_REQ_O && !DMA_RX_REQ_O, "reset pins");
		push(1'b0, 8'h11);
		CMD_VALID_I = 1'b0;
		step(60);
		set_rel(1'b1);
		step(60);
		chk(u_tgt.starts == 0 && SDA_OE_O === 1'b0, "held block ran");
	endtask
	task automatic t_speed();
		int b0;
		for (int g = 0; g < 4; g++) begin
			b0 = u_tgt.nw;
			SPEED_I = i2ci_speed_t'(g);
			lo_min = 999;
			hi_min = 999;
			hd_min = 999;
			hd_max = 0;
			push(1'b0, {6'h30, g[1:0]});
			wait_done();
			chk(u_tgt.log[b0] === 8'h54 && u_tgt.log[b0 + 1] === {6'h30, g[1:0]}, "bytes");
			chk(lo_min == SCL_CNT_I[g].clock_low_count + 1, "low phase");
			chk(hi_min > SCL_CNT_I[g].clock_high_count && hi_min < SCL_CNT_I[g].clock_high_count + 6, "high");
			chk(hd_min > 3 && hd_max < 8, "transmit hold");
		end
		SPEED_I = SPD_STD;
	endtask
	task automatic t_write();
		int b0;
		b0 = u_tgt.nw;
		push(1'b0, 8'ha5);
		push(1'b0, 8'h3c);
		wait_done();
		push(1'b0, 8'h96);
		wait_done();
		chk(u_tgt.nw == b0 + 5 && u_tgt.log[b0 + 1] === 8'ha5, "first byte");
		chk(u_tgt.log[b0 + 2] === 8'h3c && u_tgt.log[b0 + 4] === 8'h96, "data");
		chk(u_tgt.stops == u_tgt.starts && u_tgt.starts == 6, "stop then start");
	endtask
	task automatic t_comb();
		RESTART_EN_I = 1'b1;
		RX_READY_I = 1'b0;
		push(1'b0, 8'h10);
		push(1'b1, 8'h00);
		push(1'b1, 8'h00);
		wait_done();
		chk(u_tgt.starts == 8 && u_tgt.stops == 7, "repeated start");
		step(10);
		chk(RX_VALID_O === 1'b1 && RX_DATA_O === 8'h81, "first read");
		RX_READY_I = 1'b1;
		step(1);
		RX_READY_I = 1'b0;
		step(2);
		chk(RX_VALID_O === 1'b1 && RX_DATA_O === 8'h82, "second read");
		RX_READY_I = 1'b1;
		step(3);
		chk(RX_VALID_O === 1'b0, "rx drained");
	endtask
	task automatic t_ten();
		int b0;
		b0 = u_tgt.nw;
		ADDR10_I = 1'b1;
		TAR_I = 10'h2a5;
		RX_READY_I = 1'b0;
		push(1'b0, 8'h77);
		push(1'b1, 8'h00);
		wait_done();
		// turn round resends write header and low byte, then the read header
		chk(u_tgt.nw == b0 + 6 && u_tgt.log[b0] === 8'hf4, "ten");
		chk(u_tgt.log[b0 + 1] === 8'ha5 && u_tgt.log[b0 + 2] === 8'h77, "ten data");
		chk(u_tgt.log[b0 + 3] === 8'hf4 && u_tgt.log[b0 + 4] === 8'ha5, "same format");
		chk(u_tgt.log[b0 + 5] === 8'hf5, "read header");
		chk(RX_VALID_O === 1'b1 && RX_DATA_O === 8'h83, "ten bit read");
		RX_READY_I = 1'b1;
		ADDR10_I = 1'b0;
		TAR_I = 10'h02a;
		step(2);
	endtask
	task automatic t_nack();
		int n;
		n = 0;
		nack_req = 1'b1;
		push(1'b0, 8'h66);
		CMD_VALID_I = 1'b0;
		while (STATUS_O.nack !== 1'b1 && n < 5000) begin
			step(1);
			n++;
		end
		nack_req = 1'b0;
		step(2);
		chk(STATUS_O.nack === 1'b1 && INT_O === 1'b1, "nack flag");
		// head stays queued, so a retry follows the stop at once
		while (STATUS_O.done !== 1'b1 && n < 5000) begin
			step(1);
			n++;
		end
		INT_CLR_I = 2'b11;
		step(1);
		INT_CLR_I = 2'b00;
		wait_done();
		chk(u_tgt.log[u_tgt.nw - 1] === 8'h66, "retried byte");
	endtask
	task automatic t_gate();
		push(1'b0, 8'h5a);
		CMD_VALID_I = 1'b0;
		step(80);
		PWR_GATE_I = 1'b1;
		step(2);
		gate_chg = 0;
		step(200);
		chk(gate_chg == 0, "pins moved while gated");
		PWR_GATE_I = 1'b0;
		wait_done();
	endtask
	task automatic t_fill();
		int n;
		n = 0;
		// 33 reads: one in the output register, 32 left queued
		RX_READY_I = 1'b0;
		for (int i = 0; i < 33; i++) push(1'b1, 8'h00);
		wait_done();
		chk(DMA_RX_REQ_O === 1'b1, "rx dma request");
		RX_READY_I = 1'b1;
		step(40);
		chk(DMA_RX_REQ_O === 1'b0 && RX_VALID_O === 1'b0, "rx dma drained");
		chk(DMA_TX_REQ_O === 1'b1, "tx dma request");
		// frozen engine, so the queue only fills
		PWR_GATE_I = 1'b1;
		CMD_I = '{rd: 1'b0, data: 8'h00};
		CMD_VALID_I = 1'b1;
		while (CMD_READY_O === 1'b1 && n < 70) begin
			step(1);
			n++;
		end
		CMD_VALID_I = 1'b0;
		step(2);
		chk(n == 64 && DMA_TX_REQ_O === 1'b0, "tx queue depth");
		set_rel(1'b0);
		PWR_GATE_I = 1'b0;
		step(1);
		set_rel(1'b1);
		step(40);
		chk(CMD_READY_O === 1'b1 && DMA_TX_REQ_O === 1'b1 && !SDA_OE_O, "flush");
	endtask

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge CLK_I);
		mismatches++;
		$display("CHECK FAILED %0t watchdog", $time);
		test_done();
	end

	initial begin
		{SYS_RST_I, RST_WE_I, RST_REL_I, PWR_GATE_I, ADDR10_I, RESTART_EN_I} = 6'h20;
		{CMD_VALID_I, RX_READY_I, nack_req, INT_CLR_I} = 5'h08;
		{mismatches, cmp_count, gate_chg, run} = '0;
		SPEED_I = SPD_STD;
		TAR_I = 10'h02a;
		// transmit hold above its minimum, receive hold at its minimum of 8; reads run only at clock_low_count 9
		HOLD_I = 32'h0008_0005;
		CMD_I = '{rd: 1'b0, data: 8'h00};
		SCL_CNT_I[0] = '{clock_high_count: 16'h0007, clock_low_count: 16'h0009};
		SCL_CNT_I[1] = '{clock_high_count: 16'h0005, clock_low_count: 16'h0008};
		SCL_CNT_I[2] = '{clock_high_count: 16'h0004, clock_low_count: 16'h0007};
		SCL_CNT_I[3] = '{clock_high_count: 16'h0003, clock_low_count: 16'h0006};
		step(8);
		SYS_RST_I = 1'b0;
		step(2);
		t_reset();
		t_speed();
		t_write();
		t_comb();
		t_ten();
		t_nack();
		t_gate();
		t_fill();
		test_done();
	end
endmodule
`default_nettype wire
